// [rtl/sram_write_port_capture.v]
// write-port capture of a burst synchronous sram with per-lane masks
`timescale 1ns/1ps
module sram_write_port_capture #(
  parameter DATA_W = 36,
  parameter MASK_W = 4,
  parameter ADDR_W = 18
) (
  input  wire              i_clock,
  input  wire              i_sys_rst,
  input  wire              i_kclk,
  input  wire              i_kclk_n,
  input  wire              i_write_port_select_n,
  input  wire [ADDR_W-1:0] i_addr,
  input  wire [DATA_W-1:0] i_data,
  input  wire [MASK_W-1:0] i_lane_mask_n,
  input  wire [ADDR_W-1:0] i_rd_addr,
  output reg  [DATA_W-1:0] o_rd_data,
  output reg               o_write_done
);
`include "wr_capture_defines.vh"

  localparam integer BEAT_W = `BEAT_IDX_W;
  localparam integer WORDS  = `BEATS_PER_WRITE;
  localparam integer IDX_W  = ADDR_W + BEAT_W;
  localparam integer DEPTH  = (1 << ADDR_W) * WORDS;

  // burst control states
  localparam [0:0] ST_IDLE  = 1'b0;
  localparam [0:0] ST_BURST = 1'b1;

  localparam [BEAT_W-1:0] FIRST_BEAT = `BEAT_RST;
  localparam [BEAT_W-1:0] LAST_BEAT  = `BEAT_LAST_IDX;
  localparam [BEAT_W-1:0] ONE_BEAT   = `ONE_BEAT;

  // a level now against the level one cycle before
  function rise_of;
    input now_lvl;
    input last_lvl;
    begin
      rise_of = now_lvl & ~last_lvl;
    end
  endfunction

  // storage index of one beat of one row
  function [IDX_W-1:0] word_index;
    input [ADDR_W-1:0] row;
    input [BEAT_W-1:0] beat;
    begin
      word_index = {row, beat};
    end
  endfunction

  function is_last_beat;
    input [BEAT_W-1:0] beat;
    begin
      is_last_beat = (beat == LAST_BEAT);
    end
  endfunction

  // pin inputs pass two flops before any logic reads them
  reg               k_meta_r;
  reg               k_sync_r;
  reg               k_prev_r;
  reg               kn_meta_r;
  reg               kn_sync_r;
  reg               kn_prev_r;
  reg               sel_meta_r;
  reg               sel_sync_r;
  reg  [ADDR_W-1:0] addr_meta_r;
  reg  [ADDR_W-1:0] addr_sync_r;
  reg  [DATA_W-1:0] data_meta_r;
  reg  [DATA_W-1:0] data_sync_r;
  reg  [MASK_W-1:0] mask_meta_r;
  reg  [MASK_W-1:0] mask_sync_r;
  reg  [ADDR_W-1:0] rdaddr_meta_r;
  reg  [ADDR_W-1:0] rdaddr_sync_r;

  // no reset on the chains: a reset edge-history would fake a rise after reset
  always @(posedge i_clock) begin
    k_meta_r <= i_kclk;
    k_sync_r <= k_meta_r;
    k_prev_r <= k_sync_r;
  end

  always @(posedge i_clock) begin
    kn_meta_r <= i_kclk_n;
    kn_sync_r <= kn_meta_r;
    kn_prev_r <= kn_sync_r;
  end

  always @(posedge i_clock) begin
    sel_meta_r <= i_write_port_select_n;
    sel_sync_r <= sel_meta_r;
  end

  always @(posedge i_clock) begin
    addr_meta_r <= i_addr;
    addr_sync_r <= addr_meta_r;
  end

  // data and masks share the clocks' delay, so a beat lines up with its edge
  always @(posedge i_clock) begin
    data_meta_r <= i_data;
    data_sync_r <= data_meta_r;
  end

  always @(posedge i_clock) begin
    mask_meta_r <= i_lane_mask_n;
    mask_sync_r <= mask_meta_r;
  end

  always @(posedge i_clock) begin
    rdaddr_meta_r <= i_rd_addr;
    rdaddr_sync_r <= rdaddr_meta_r;
  end

  reg               state_r;
  reg               state_nxt;
  reg  [BEAT_W-1:0] beat_r;
  reg  [BEAT_W-1:0] beat_nxt;
  reg  [ADDR_W-1:0] row_r;
  reg  [ADDR_W-1:0] row_nxt;
  reg               done_nxt;
  reg  [DATA_W-1:0] mem [0:DEPTH-1];
  wire [DATA_W-1:0] merged;
  wire              k_rise;
  wire              kn_rise;
  wire              start_edge;
  wire              beat_edge;
  wire [IDX_W-1:0]  wr_idx;
  wire [IDX_W-1:0]  rd_idx;

  // pin clocks are oversampled: each level must hold several system clocks
  assign k_rise     = rise_of(k_sync_r, k_prev_r);
  assign kn_rise    = rise_of(kn_sync_r, kn_prev_r);
  assign start_edge = k_rise & ~sel_sync_r;
  assign beat_edge  = (state_r == ST_BURST) & (k_rise | kn_rise);
  assign wr_idx     = word_index(row_r, beat_r);
  assign rd_idx     = word_index(rdaddr_sync_r, FIRST_BEAT);

  lane_merge #(.DATA_W(DATA_W), .MASK_W(MASK_W)) u_merge (
    .i_old_word (mem[wr_idx]),
    .i_new_word (data_sync_r),
    .i_mask_n   (mask_sync_r),
    .o_word     (merged)
  );

  // a new burst is taken only once the previous four beats are in
  always @* begin
    state_nxt = state_r;
    beat_nxt  = beat_r;
    row_nxt   = row_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start_edge) begin
          state_nxt = ST_BURST;
          row_nxt   = addr_sync_r;
          beat_nxt  = FIRST_BEAT;
        end
        // select high on a true rise starts nothing, data ignored
      end
      ST_BURST: begin
        if (beat_edge) begin
          beat_nxt = beat_r + ONE_BEAT;
          if (is_last_beat(beat_r)) begin
            state_nxt = ST_IDLE;
            done_nxt  = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      beat_r <= FIRST_BEAT;
    end else begin
      beat_r <= beat_nxt;
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      row_r <= {ADDR_W{`ROW_RST_BIT}};
    end else begin
      row_r <= row_nxt;
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_write_done <= `DONE_RST;
    end else begin
      o_write_done <= done_nxt;
    end
  end

  // storage holds no reset, as the array itself has none
  always @(posedge i_clock) begin
    if (beat_edge) begin
      mem[wr_idx] <= merged;
    end
  end

  // debug read sees word 0 of a row, three cycles after the address pins
  always @(posedge i_clock) begin
    o_rd_data <= mem[rd_idx];
  end

endmodule

// [rtl/wr_capture_defines.vh]
// constants for the write-port capture block
`ifndef WR_CAPTURE_DEFINES_VH
`define WR_CAPTURE_DEFINES_VH
`define BEATS_PER_WRITE   3'h4
`define BEAT_IDX_W        2
`define BEAT_RST          2'h0
`define BEAT_LAST_IDX     2'h3
`define ONE_BEAT          2'h1
`define ROW_RST_BIT       1'b0
`define DONE_RST          1'b0
`define LANE_BITS         9
`define NIBBLE_BITS       4
`define NARROW_WIDTH      8
`endif

// [rtl/lane_merge.v]
// per-beat lane mask merge of new data over stored word
`timescale 1ns/1ps
module lane_merge #(
  parameter DATA_W = 36,
  parameter MASK_W = 4
) (
  input  wire [DATA_W-1:0] i_old_word,
  input  wire [DATA_W-1:0] i_new_word,
  input  wire [MASK_W-1:0] i_mask_n,
  output reg  [DATA_W-1:0] o_word
);
`include "wr_capture_defines.vh"
  integer b;
  integer lane;
  always @* begin
    o_word = i_old_word;
    for (b = 0; b < DATA_W; b = b + 1) begin
      if (DATA_W == `NARROW_WIDTH)
        lane = b / `NIBBLE_BITS;
      else
        lane = b / `LANE_BITS;
      if (lane < MASK_W && !i_mask_n[lane])
        o_word[b] = i_new_word[b];
    end
  end
endmodule

// [test/wr_capture_properties.sv]
// port assertions for the write-port capture block
`timescale 1ns/1ps
module wr_capture_chk (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_kclk,
  input wire i_kclk_n,
  input wire o_write_done
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_pins_still;
    ($stable(i_kclk) && $stable(i_kclk_n)) [*6];
  endsequence
  sequence s_done_gap;
    !o_write_done [*5];
  endsequence
  a_done_one_cycle: assert property (o_write_done |=> !o_write_done)
    else $error("done too wide");
  a_done_true_edge: assert property (o_write_done |-> i_kclk && !i_kclk_n)
    else $error("done off true edge");
  a_done_burst_gap: assert property (o_write_done |=> s_done_gap)
    else $error("bursts closer than four rises");
  a_done_k_held: assert property (o_write_done |-> $past(i_kclk, 2) && !$past(i_kclk_n, 2))
    else $error("done without true rise");
  a_still_no_done: assert property (s_pins_still |=> !o_write_done)
    else $error("done without clock edges");
  a_rst_no_done: assert property (disable iff (1'b0) i_sys_rst |=> !o_write_done)
    else $error("done after reset");
endmodule
bind sram_write_port_capture wr_capture_chk chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_kclk(i_kclk), .i_kclk_n(i_kclk_n), .o_write_done(o_write_done));

// [test/ctrl_model.sv]
// memory controller model driving the write port
`timescale 1ns/1ps
module ctrl_model (
  input  wire        i_clock,
  output reg         k,
  output reg         kn,
  output reg         sel_n,
  output reg  [3:0]  a,
  output reg  [35:0] d,
  output reg  [3:0]  m
);
  initial begin k = 0; kn = 1; sel_n = 1; a = 0; d = 0; m = 4'hF; end
  // beats held 8 clocks each side of a rise, well above the sync depth
  task step; begin repeat (8) @(posedge i_clock); #2; end endtask
  task burst(input [3:0] ad, input [35:0] dat, input [3:0] msk, input s);
    integer n;
    begin
      sel_n = s; a = ad; step; k = 1; kn = 0; step;
      sel_n = 1; a = ~ad;
      for (n = 0; n < 4; n = n + 1) begin
        d = n ? ~dat : dat; m = msk; step; {k, kn} = {kn, k}; step;
        d = ~d; m = ~m;
      end
      {k, kn} = 2'b01; step;
    end
  endtask
endmodule

// [test/tb_top.sv]
// self-checking bench for the write-port capture block
`timescale 1ns/1ps
module tb_top;
  localparam [35:0] W_FULL = 36'h123456789;
  localparam [35:0] W_NEW  = 36'hFEDCBA987;
  localparam [35:0] KEEP02 = 36'h007FC01FF;
  localparam [35:0] W_MASK = (W_FULL & KEEP02) | (W_NEW & ~KEEP02);
  reg         i_clock = 1'b0;
  reg         i_sys_rst = 1'b1;
  wire        k;
  wire        kn;
  wire        sel_n;
  wire        done;
  wire        done8;
  wire [3:0]  a;
  wire [3:0]  m;
  wire [35:0] d;
  wire [35:0] q;
  wire [7:0]  q8;
  integer     errors = 0;
  integer     check_count = 0;
  integer     dones = 0;
  integer     dones8 = 0;
  integer     cyc = 0;
  always #12.5 i_clock = ~i_clock;
  ctrl_model mdl (.i_clock(i_clock), .k(k), .kn(kn), .sel_n(sel_n), .a(a), .d(d), .m(m));
  sram_write_port_capture #(.ADDR_W(4)) uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_kclk(k), .i_kclk_n(kn), .i_write_port_select_n(sel_n), .i_addr(a), .i_data(d),
    .i_lane_mask_n(m), .i_rd_addr(4'h3), .o_rd_data(q), .o_write_done(done));
  // narrow configuration with nibble masks on the low pins
  sram_write_port_capture #(.DATA_W(8), .MASK_W(2), .ADDR_W(4)) uut_narrow (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_kclk(k), .i_kclk_n(kn),
    .i_write_port_select_n(sel_n), .i_addr(a), .i_data(d[7:0]), .i_lane_mask_n(m[1:0]),
    .i_rd_addr(4'h3), .o_rd_data(q8), .o_write_done(done8));
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (done === 1'b1) dones = dones + 1;
    if (done8 === 1'b1) dones8 = dones8 + 1;
    if (cyc == 4000) begin errors = errors + 1; stop_test; end
  end
  task stop_test;
    begin
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [35:0] e, input [7:0] e8, input integer n);
    begin
      check_count = check_count + 1;
      @(posedge i_clock); #2;
      if (q !== e || q8 !== e8 || dones !== n || dones8 !== n) begin
        errors = errors + 1;
        $display("Error %0t: word %h narrow %h done count %0d", $time, q, q8, dones);
      end
    end
  endtask
  task t_full; begin mdl.burst(4'h3, W_FULL, 4'h0, 1'b0); chk(W_FULL, 8'h89, 1); end endtask
  // lanes 0 and 2 masked keep the old word; narrow: nibble 0 masked
  task t_mask; begin mdl.burst(4'h3, W_NEW, 4'h5, 1'b0); chk(W_MASK, 8'h89, 2); end endtask
  task t_desel; begin mdl.burst(4'h3, 36'h0, 4'h0, 1'b1); chk(W_MASK, 8'h89, 2); end endtask
  task t_nibble;
    begin
      mdl.burst(4'h3, 36'h00000000C, 4'hE, 1'b0);
      chk((W_MASK & ~36'h1FF) | 36'h00C, 8'h8C, 3);
    end
  endtask
  initial begin
    repeat (2) @(posedge i_clock); #2 i_sys_rst = 0;
    t_full; t_mask; t_desel; t_nibble;
    stop_test;
  end
endmodule
